// file: pmbsl_pkg.sv
// Shared constants and types of the two-wire management slave.
// Assumes a 250 MHz core clock and a bus clock no faster than 400 kHz.
package pmbsl_pkg;

    // ************************************************************
    // Addresses
    // ************************************************************
    localparam logic [6:0] GLOBAL_ADDR = 7'h5A;  // Unpaged, cannot be disabled.
    localparam logic [6:0] ARA_ADDR    = 7'h0C;  // Alert response address.
    localparam logic [7:0] ADDR_OFF    = 8'h80;  // Device address disabled.

    // ************************************************************
    // Setting bit positions
    // ************************************************************
    localparam int CFG_STRETCH_BIT   = 1;
    localparam int CFG_LONG_TO_BIT   = 3;
    localparam int CHAN_NO_ALERT_BIT = 1;
    localparam int CHAN_CFG_W        = 8;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int         CLK_PERIOD_NS = 4;
    localparam int         MS_NS         = 1000000;
    localparam int         MS_CYC        = MS_NS / CLK_PERIOD_NS;
    localparam logic [8:0] TO_SHORT_MS   = 9'h01E;  // 30 ms.
    localparam logic [8:0] TO_LONG_MS    = 9'h0FF;  // 255 ms.
    localparam logic [7:0] BLK_FREE_LEN  = 8'h20;   // 32 bytes at no extra time.
    localparam int         STRETCH_NS    = 1000;
    localparam logic [8:0] STRETCH_CYC   =
        9'((STRETCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    // ************************************************************
    // Framing
    // ************************************************************
    localparam logic [3:0] LAST_BIT = 4'h7;
    localparam logic [7:0] CRC_POLY = 8'h07;
    localparam logic [7:0] IDLE_BYTE = 8'hFF;

    typedef enum logic [2:0] {
        ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_WR, ST_WR_ACK, ST_RD, ST_RD_ACK, ST_SKIP
    } pmbsl_state_t;

endpackage

// file: pmbsl_crc8.sv
// Byte-wide packet error code generator, polynomial x^8+x^2+x+1.
// Assumes bytes are offered one per strobe in the core clock domain.
`timescale 1ns/1ps
`default_nettype none
module pmbsl_crc8 (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       reset_n,
    // Byte stream
    input  wire logic       clear,
    input  wire logic       feed,
    input  wire logic [7:0] data,
    // Running remainder
    output logic      [7:0] crc
);
    logic [7:0] next_crc;

    // One byte folded in per strobe, most significant bit first.
    always_comb begin
        logic [7:0] c;
        c = crc ^ data;
        for (int i = 0; i < 8; i++) begin
            c = c[7] ? ({c[6:0], 1'b0} ^ pmbsl_pkg::CRC_POLY) : {c[6:0], 1'b0};
        end
        if (clear) begin
            next_crc = 8'h00;
        end else if (feed) begin
            next_crc = c;
        end else begin
            next_crc = crc;
        end
    end

    // Remainder register.
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            crc <= 8'h00;
        end else begin
            crc <= next_crc;
        end
    end
endmodule
`default_nettype wire

// file: pmbsl_slave.sv
// Two-wire management slave with packet timeout and fault-pin reporting.
// Assumes open-drain pads outside; SCL also clocks the bit-capture logic.
//
// Overview of operation
// - Timer starts at first START; after 30 ms release lines, drop packet.
// - Global setting bit 3 stretches the packet timeout to 255 ms.
// - Timing spans address, command, repeated start, data and error code.
// - Block reads add 1 ms per length byte beyond 32.
// - Works for any bus clock from 10 kHz to 400 kHz.
// - Master polls above 100 kHz; device stretches only when bit 1 set.
// - Slave only: receives on writes, transmits on reads, never initiates.
// - Send/write byte/word, read byte/word, block read/write, alert response.
// - Optional error code byte on every transaction except the alert response.
// - Block reads may return up to 255 data bytes.
// - On immediate reads, roles reverse at the first acknowledge.
// - Read is 1, write 0; ACK is 0, NACK is 1.
// - Send byte: START, address, write, ACK, command, ACK, opt code, STOP.
// - Fault pin low: clear pad bit, set status bits, pull alert low.
// - No alert from fault pin if channel bit 1 set or masked.
// - Appended error code on a write never blocks execution.
// - Answer global address 0x5A; commands there are flagged on cmd_global.
// - Device address setting 0x80 disables the device address only.
`timescale 1ns/1ps
`default_nettype none
module pmbsl_slave #(
    parameter int MS_CYC = pmbsl_pkg::MS_CYC
) (
    // Core clock and reset
    input  wire logic        clk,
    input  wire logic        reset_n,
    // Bus pins
    input  wire logic        scl_clk,
    input  wire logic        sda_i,
    output logic             sda_o,
    output logic             sda_oe,
    output logic             scl_o,
    output logic             scl_oe,
    output logic             alert_o,
    output logic             alert_oe,
    // Settings
    input  wire logic [7:0]  device_addr_setting,
    input  wire logic [7:0]  global_config_setting,
    input  wire logic [15:0] channel_config_setting,
    input  wire logic [1:0]  alert_mask,
    // Fault pins and status
    input  wire logic [1:0]  ext_fault_pin,
    input  wire logic        fault_clr,
    output logic      [1:0]  pad_state_readback,
    output logic      [1:0]  vendor_status_bits,
    output logic             none_of_above,
    // Write stream
    output logic             wr_valid,
    output logic      [7:0]  wr_data,
    output logic      [7:0]  wr_index,
    output logic             cmd_done,
    output logic             cmd_global,
    output logic      [7:0]  wr_count,
    output logic             pec_ok,
    output logic             timeout,
    // Read source
    output logic      [7:0]  rd_index,
    input  wire logic [7:0]  rd_data,
    input  wire logic [7:0]  rd_count,
    input  wire logic        rd_pec_en,
    input  wire logic        rd_block
);
    // ************************************************************
    // Link side, clocked by the bus clock
    // ************************************************************
    logic link_bit, next_link_bit;

    // Each rising bus-clock edge captures one bit. No reset here: an idle bus
    // has no clock edges to take one, and the core reads the bit only after
    // it has seen the synchronised rise that captured it.
    always_comb begin
        next_link_bit = sda_i;
    end

    // The captured bit holds a whole bus period, so the core may read it.
    always_ff @(posedge scl_clk) begin
        link_bit <= next_link_bit;
    end

    // ************************************************************
    // Pin synchronisers
    // ************************************************************
    logic       sda_s1, sda_s2, sda_d, scl_s1, scl_s2, scl_d;
    logic [1:0] flt_s1, flt_d;

    // Two stages before any core-clock logic looks at a pin.
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            {sda_s1, sda_s2, sda_d} <= 3'h7;
            {scl_s1, scl_s2, scl_d} <= 3'h7;
            flt_s1                  <= 2'h3;
            pad_state_readback      <= 2'h3;
            flt_d                   <= 2'h3;
        end else begin
            {sda_s1, sda_s2, sda_d} <= {sda_i, sda_s1, sda_s2};
            {scl_s1, scl_s2, scl_d} <= {scl_clk, scl_s1, scl_s2};
            flt_s1                  <= ext_fault_pin;
            pad_state_readback      <= flt_s1;
            flt_d                   <= pad_state_readback;
        end
    end

    logic start_ev, stop_ev, scl_fall, bit_ev;
    assign start_ev = scl_s2 & scl_d & sda_d & ~sda_s2;
    assign stop_ev  = scl_s2 & scl_d & ~sda_d & sda_s2;
    assign scl_fall = scl_d & ~scl_s2;
    assign bit_ev   = scl_s2 & ~scl_d;  // Rise seen; the captured bit is settled.

    // ************************************************************
    // Packet timer
    // ************************************************************
    logic [17:0] ms_div, next_ms_div;
    logic [8:0]  ms_cnt, next_ms_cnt, extra, next_extra, limit;
    logic        active, next_active, to_hit;

    assign limit  = (global_config_setting[pmbsl_pkg::CFG_LONG_TO_BIT] ?
                     pmbsl_pkg::TO_LONG_MS : pmbsl_pkg::TO_SHORT_MS) + extra;
    assign to_hit = active && (ms_cnt >= limit);

    always_comb begin
        next_active = active;
        next_ms_div = ms_div;
        next_ms_cnt = ms_cnt;
        if (to_hit || stop_ev) begin
            next_active = 1'b0;
        end else if (start_ev) begin
            next_active = 1'b1;
        end
        if (!active || to_hit || stop_ev) begin
            next_ms_div = 18'h00000;
            next_ms_cnt = 9'h000;
        end else if (ms_div == 18'(MS_CYC - 1)) begin
            next_ms_div = 18'h00000;
            next_ms_cnt = ms_cnt + 9'h001;
        end else begin
            next_ms_div = ms_div + 18'h00001;
        end
    end

    // Timer registers.
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            active <= 1'b0;
            ms_div <= 18'h00000;
            ms_cnt <= 9'h000;
        end else begin
            active <= next_active;
            ms_div <= next_ms_div;
            ms_cnt <= next_ms_cnt;
        end
    end

    // ************************************************************
    // Byte framing
    // ************************************************************
    pmbsl_pkg::pmbsl_state_t state, next_state;
    logic [3:0] cnt, next_cnt;
    logic [7:0] sh, next_sh, tx, next_tx, idx, next_idx, sh_in, tx_pick, crc;
    logic       rw, next_rw, glob, next_glob, ara, next_ara, alert_act;
    logic       next_sda_oe, next_wr_valid, next_cmd_done, next_timeout;
    logic       next_cmd_global, next_pec_ok, crc_clr, crc_feed, ara_hit;
    logic [7:0] next_wr_data, next_wr_index, next_wr_count, crc_byte;
    logic       hit_dev, hit_glob, hit_ara;

    assign sh_in    = {sh[6:0], link_bit};
    assign hit_dev  = (sh_in[7:1] == device_addr_setting[6:0]) &&
                      (device_addr_setting != pmbsl_pkg::ADDR_OFF);
    assign hit_glob = (sh_in[7:1] == pmbsl_pkg::GLOBAL_ADDR);
    assign hit_ara  = (sh_in[7:1] == pmbsl_pkg::ARA_ADDR) && link_bit && alert_act;

    // Read byte source, error code after the last data byte
    always_comb begin
        if (ara) begin
            tx_pick = {device_addr_setting[6:0], 1'b0};
        end else if (idx < rd_count) begin
            tx_pick = rd_data;
        end else if ((idx == rd_count) && rd_pec_en) begin
            tx_pick = crc;
        end else begin
            tx_pick = pmbsl_pkg::IDLE_BYTE;
        end
    end

    // Protocol engine: bit events, edges of the bus clock, start and stop.
    always_comb begin
        next_state = state;      next_cnt = cnt;       next_sh = sh;
        next_tx = tx;            next_idx = idx;       next_rw = rw;
        next_glob = glob;        next_ara = ara;       next_extra = extra;
        next_sda_oe = sda_oe;    next_wr_valid = 1'b0; next_cmd_done = 1'b0;
        next_timeout = 1'b0;     next_wr_data = wr_data;
        next_wr_index = wr_index; next_wr_count = wr_count;
        next_cmd_global = cmd_global; next_pec_ok = pec_ok;
        crc_clr = 1'b0;          crc_feed = 1'b0;      crc_byte = sh_in;
        ara_hit = 1'b0;
        if (to_hit) begin
            next_state  = pmbsl_pkg::ST_IDLE;
            next_sda_oe = 1'b0;
            next_timeout = 1'b1;
        end else if (start_ev) begin
            // Repeated start stays in the timed packet
            if (state == pmbsl_pkg::ST_IDLE) begin
                crc_clr    = 1'b1;
                next_idx   = 8'h00;
                next_extra = 9'h000;
            end
            next_state  = pmbsl_pkg::ST_ADDR;
            next_cnt    = 4'h0;
            next_sda_oe = 1'b0;
        end else if (stop_ev) begin
            // Write executes whether or not a code byte came
            if (!rw && (idx != 8'h00) && (state != pmbsl_pkg::ST_SKIP) &&
                (state != pmbsl_pkg::ST_IDLE)) begin
                next_cmd_done   = 1'b1;
                next_wr_count   = idx;
                next_cmd_global = glob;
                next_pec_ok     = (crc == 8'h00);
            end
            next_state  = pmbsl_pkg::ST_IDLE;
            next_sda_oe = 1'b0;
        end else if (bit_ev) begin
            case (state)
                pmbsl_pkg::ST_ADDR: begin
                    next_sh  = sh_in;
                    next_cnt = cnt + 4'h1;
                    if (cnt == pmbsl_pkg::LAST_BIT) begin
                        if (hit_dev || hit_glob || hit_ara) begin
                            next_rw    = link_bit;
                            next_glob  = hit_glob;
                            next_ara   = hit_ara;
                            next_state = pmbsl_pkg::ST_ADDR_ACK;
                            crc_feed   = 1'b1;
                            if (link_bit) begin
                                next_idx = 8'h00;
                            end
                        end else begin
                            next_state = pmbsl_pkg::ST_SKIP;
                        end
                    end
                end
                pmbsl_pkg::ST_ADDR_ACK: begin
                    next_cnt = 4'h0;
                    // Roles reverse at the first acknowledge
                    if (rw) begin
                        next_state = pmbsl_pkg::ST_RD;
                        next_tx    = tx_pick;
                        next_idx   = idx + 8'h01;
                        crc_feed   = 1'b1;
                        crc_byte   = tx_pick;
                        ara_hit    = ara;
                        // Extra time for long blocks, from the length byte
                        if (rd_block && !ara && (tx_pick > pmbsl_pkg::BLK_FREE_LEN)) begin
                            next_extra = {1'b0, tx_pick - pmbsl_pkg::BLK_FREE_LEN};
                        end
                    end else begin
                        next_state = pmbsl_pkg::ST_WR;
                    end
                end
                pmbsl_pkg::ST_WR: begin
                    next_sh  = sh_in;
                    next_cnt = cnt + 4'h1;
                    // Every received byte, code byte included, is passed on
                    if (cnt == pmbsl_pkg::LAST_BIT) begin
                        next_wr_valid = 1'b1;
                        next_wr_data  = sh_in;
                        next_wr_index = idx;
                        next_idx      = idx + 8'h01;
                        crc_feed      = 1'b1;
                        next_state    = pmbsl_pkg::ST_WR_ACK;
                    end
                end
                pmbsl_pkg::ST_WR_ACK: begin
                    next_cnt   = 4'h0;
                    next_state = pmbsl_pkg::ST_WR;
                end
                pmbsl_pkg::ST_RD: begin
                    next_cnt = cnt + 4'h1;
                    if (cnt == pmbsl_pkg::LAST_BIT) begin
                        next_state = pmbsl_pkg::ST_RD_ACK;
                    end
                end
                pmbsl_pkg::ST_RD_ACK: begin
                    next_cnt = 4'h0;
                    if (link_bit) begin
                        next_state = pmbsl_pkg::ST_SKIP;
                    end else begin
                        next_state = pmbsl_pkg::ST_RD;
                        next_tx    = tx_pick;
                        next_idx   = idx + 8'h01;
                        crc_feed   = 1'b1;
                        crc_byte   = tx_pick;
                    end
                end
                default: begin
                end
            endcase
        end else if (scl_fall) begin
            // Data changes only while the master holds the clock low
            case (state)
                pmbsl_pkg::ST_ADDR_ACK, pmbsl_pkg::ST_WR_ACK: begin
                    next_sda_oe = 1'b1;
                end
                pmbsl_pkg::ST_RD: begin
                    next_sda_oe = ~tx[7];
                    next_tx     = {tx[6:0], 1'b1};
                end
                default: begin
                    next_sda_oe = 1'b0;
                end
            endcase
        end
    end

    // Framing registers.
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            state <= pmbsl_pkg::ST_IDLE;
            {cnt, sh, tx, idx, extra} <= '0;
            {rw, glob, ara, sda_oe, wr_valid, cmd_done, timeout} <= '0;
            {wr_data, wr_index, wr_count, cmd_global, pec_ok} <= '0;
        end else begin
            state <= next_state;  cnt <= next_cnt;  sh <= next_sh;
            tx <= next_tx;        idx <= next_idx;  extra <= next_extra;
            rw <= next_rw;        glob <= next_glob; ara <= next_ara;
            sda_oe <= next_sda_oe; wr_valid <= next_wr_valid;
            cmd_done <= next_cmd_done; timeout <= next_timeout;
            wr_data <= next_wr_data; wr_index <= next_wr_index;
            wr_count <= next_wr_count; cmd_global <= next_cmd_global;
            pec_ok <= next_pec_ok;
        end
    end

    assign rd_index = idx;

    // Error code over the whole packet, written and read bytes alike.
    pmbsl_crc8 u_crc (
        .clk     (clk),
        .reset_n (reset_n),
        .clear   (crc_clr),
        .feed    (crc_feed),
        .data    (crc_byte),
        .crc     (crc)
    );

    // ************************************************************
    // Clock stretching
    // ************************************************************
    logic [8:0] str_cnt, next_str_cnt;
    logic       next_scl_oe;

    // Hold the clock low after each acknowledge, only when enabled.
    always_comb begin
        next_str_cnt = (str_cnt != 9'h000) ? str_cnt - 9'h001 : 9'h000;
        if (scl_fall && (cnt == 4'h0) && !to_hit &&
            global_config_setting[pmbsl_pkg::CFG_STRETCH_BIT] &&
            ((state == pmbsl_pkg::ST_WR) || (state == pmbsl_pkg::ST_RD))) begin
            next_str_cnt = pmbsl_pkg::STRETCH_CYC;
        end
        if (to_hit) begin
            next_str_cnt = 9'h000;
        end
        next_scl_oe = (next_str_cnt != 9'h000);
    end

    // Stretch registers.
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            str_cnt <= 9'h000;
            scl_oe  <= 1'b0;
        end else begin
            str_cnt <= next_str_cnt;
            scl_oe  <= next_scl_oe;
        end
    end

    // ************************************************************
    // Fault pins and alert
    // ************************************************************
    logic [1:0] flt_fall, alert_req, next_vendor;
    logic       next_noa, next_alert;

    assign flt_fall = flt_d & ~pad_state_readback;

    for (genvar ch = 0; ch < 2; ch++) begin : g_chan
        assign alert_req[ch] = flt_fall[ch] & ~alert_mask[ch] &
            ~channel_config_setting[ch * pmbsl_pkg::CHAN_CFG_W + pmbsl_pkg::CHAN_NO_ALERT_BIT];
    end

    // Sticky status, a new fault wins over a clear in the same cycle.
    always_comb begin
        next_vendor = (fault_clr ? 2'h0 : vendor_status_bits) | flt_fall;
        next_noa    = (none_of_above & ~fault_clr) | (|flt_fall);
        next_alert  = (alert_act & ~fault_clr & ~ara_hit) | (|alert_req);
    end

    // Status registers; the alert pin is only ever pulled low.
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            vendor_status_bits <= 2'h0;
            none_of_above      <= 1'b0;
            alert_act          <= 1'b0;
            alert_oe           <= 1'b0;
        end else begin
            vendor_status_bits <= next_vendor;
            none_of_above      <= next_noa;
            alert_act          <= next_alert;
            alert_oe           <= next_alert;
        end
    end

    // Lines are only ever pulled low.
    assign sda_o   = 1'b0;
    assign scl_o   = 1'b0;
    assign alert_o = 1'b0;
endmodule
`default_nettype wire

// file: pmbsl_props.sv
// Checker for the management slave pins, fault status and strobes.
// Assumes it is bound to every pmbsl_slave and sees its ports only.
`timescale 1ns/1ps
`default_nettype none
module pmbsl_props (
    // Clock, reset and pads
    input wire logic        clk, reset_n, sda_o, scl_o, alert_o, sda_oe, scl_oe, alert_oe,
    // Strobes and status
    input wire logic        wr_valid, cmd_done, timeout, none_of_above,
    // Settings, fault pins and their status
    input wire logic [7:0]  global_config_setting,
    input wire logic [15:0] channel_config_setting,
    input wire logic [1:0]  alert_mask, ext_fault_pin, pad_state_readback, vendor_status_bits
);
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    // Pads may only pull low, so a high drive would fight the pull-ups.
    a_lines_low: assert property (!sda_o && !scl_o && !alert_o)
        else $error("pad driven high");
    a_no_stretch: assert property (!global_config_setting[1] |-> !scl_oe)
        else $error("stretch while disabled");
    a_to_release: assert property (timeout |=> !sda_oe && !scl_oe)
        else $error("bus held after timeout");
    a_wr_pulse: assert property (wr_valid |=> !wr_valid)
        else $error("byte strobe too long");
    a_fault_status: assert property ($fell(ext_fault_pin[0]) |-> ##[1:5]
        vendor_status_bits[0] && none_of_above) else $error("fault status missing");
    a_fault_pad: assert property (!ext_fault_pin[1] [*4] |-> !pad_state_readback[1])
        else $error("pad readback stale");
    a_fault_alert: assert property ($fell(ext_fault_pin[0]) && !alert_mask[0]
        && !channel_config_setting[1] |-> ##[1:5] alert_oe) else $error("alert missing");
    a_alert_block: assert property ((channel_config_setting[1] | alert_mask[0]) &&
        (channel_config_setting[9] | alert_mask[1]) |-> !$rose(alert_oe))
        else $error("alert while blocked");
    c_timeout: cover property (timeout);
    c_done: cover property (cmd_done);
    c_alert: cover property ($rose(alert_oe));
    c_stretch: cover property ($rose(scl_oe));
endmodule
bind pmbsl_slave pmbsl_props props_u (.*);
`default_nettype wire

// file: pmbsl_master.sv
// Bus master model: open-drain lines with pull-ups and bit-level tasks.
// Assumes the core clock paces it; the bus clock stays at 400 kHz or below.
`timescale 1ns/1ps
`default_nettype none
module pmbsl_master (
    input  wire logic clk, sda_oe, scl_oe,
    output wire logic sda, scl
);
    localparam int H = 300;  // Half bus period in core cycles.
    logic m_sda = 1'b1;
    logic m_scl = 1'b1;
    assign sda = m_sda & ~sda_oe;
    assign scl = m_scl & ~scl_oe;
    task automatic hc;
        repeat (H) @(negedge clk);
    endtask
    task automatic bitx(input logic b, output logic r);
        m_sda = b;
        hc();
        m_scl = 1'b1;
        while (!scl) @(negedge clk);
        hc();
        r = sda;
        m_scl = 1'b0;
        repeat (25) @(negedge clk);  // Hold time, so no data moves with SCL.
    endtask
    task automatic start;
        m_sda = 1'b1;
        hc();
        m_scl = 1'b1;
        hc();
        m_sda = 1'b0;
        hc();
        m_scl = 1'b0;
    endtask
    task automatic stop;
        m_sda = 1'b0;
        hc();
        m_scl = 1'b1;
        hc();
        m_sda = 1'b1;
    endtask
    task automatic wbyte(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--) bitx(b[i], ack);
        bitx(1'b1, ack);
    endtask
    task automatic rbyte(output logic [7:0] b, input logic nack);
        logic r;
        for (int i = 7; i >= 0; i--) bitx(1'b1, b[i]);
        bitx(nack, r);
    endtask
endmodule
`default_nettype wire

// file: tb_top.sv
// Bench for the management slave: writes, read, timeout and fault pins.
// Assumes the master model and bound checker are compiled before it.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin n_errors++; \
    $display("wrong value at %0t: got %h", $time, a); end end
module tb_top;
    logic       clk, reset_n, sda_o, sda_oe, scl_o, scl_oe, alert_o, alert_oe, fault_clr;
    logic       wr_valid, cmd_done, cmd_global, pec_ok, timeout, rd_pec_en, rd_block, ack;
    logic       none_of_above;
    logic [7:0] device_addr_setting, global_config_setting, wr_data, wr_index, wr_count;
    logic [7:0] rd_index, rd_data, rd_count, rb;
    logic [15:0] channel_config_setting;
    logic [1:0] alert_mask, ext_fault_pin, pad_state_readback, vendor_status_bits;
    wire        scl, sda;
    int         n_errors, cmp_count;
    time        t0;
    assign rd_data = rd_index + 8'hC3;  // Read source answers from the index.
    pmbsl_slave #(.MS_CYC(1000)) dut_u (.*, .scl_clk(scl), .sda_i(sda));
    pmbsl_master m_u (.clk(clk), .sda_oe(sda_oe), .scl_oe(scl_oe), .sda(sda), .scl(scl));
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    task automatic conclude;
        $display("mismatches %0d, compares %0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // Three-byte write, address and data bytes checked for acknowledge.
    task automatic wr(input logic [6:0] a, input logic [7:0] c, d, input logic g, p);
        m_u.start();
        m_u.wbyte({a, 1'b0}, ack);
        `CHK(ack, 1'b0)
        m_u.wbyte(c, ack);
        m_u.wbyte(d, ack);
        `CHK(ack, 1'b0)
        m_u.stop();
        repeat (8) @(negedge clk);
        `CHK({wr_count, cmd_global, pec_ok, wr_data, wr_index}, {8'h02, g, p, d, 8'h01})
    endtask
    initial begin
        {reset_n, fault_clr, rd_pec_en, rd_block} = 4'h0;
        {rd_count, global_config_setting, device_addr_setting} = 24'h02_00_31;
        {channel_config_setting, alert_mask, ext_fault_pin} = 20'h0000B;
        repeat (4) @(negedge clk);
        reset_n = 1'b1;
        repeat (4) @(negedge clk);
        // Send byte with its error code appended (D8 closes the remainder to zero).
        wr(7'h31, 8'h01, 8'hD8, 1'b0, 1'b1);
        device_addr_setting = 8'h80;
        global_config_setting = 8'h02;  // Stretching on from here; the master honours it.
        wr(7'h5A, 8'h03, 8'hE7, 1'b1, 1'b0);
        // Address zero would match the disabled setting's low bits.
        m_u.start();
        m_u.wbyte(8'h00, ack);
        `CHK(ack, 1'b1)
        m_u.stop();
        device_addr_setting = 8'h31;
        // Combined read through a repeated start, last byte refused.
        m_u.start();
        m_u.wbyte(8'h62, ack);
        m_u.wbyte(8'h8B, ack);
        m_u.start();
        m_u.wbyte(8'h63, ack);
        m_u.rbyte(rb, 1'b0);
        `CHK(rb, 8'hC3)
        m_u.rbyte(rb, 1'b1);
        `CHK(rb, 8'hC4)
        m_u.stop();
        // Stalled packet: the timer runs from the START, H cycles before t0.
        m_u.start();
        t0 = $time;
        m_u.wbyte(8'h62, ack);
        for (int i = 0; i < 31000 && timeout !== 1'b1; i++) @(negedge clk);
        `CHK((($time - t0) / 4 + m_u.H - 30000) < 10, 1'b1)
        repeat (2) @(negedge clk);
        `CHK({sda_oe, scl_oe}, 2'h0)
        m_u.stop();
        ext_fault_pin = 2'h2;
        repeat (8) @(negedge clk);
        `CHK({pad_state_readback, vendor_status_bits, none_of_above, alert_oe}, 6'h27)
        fault_clr = 1'b1;
        @(negedge clk);
        {fault_clr, ext_fault_pin, channel_config_setting} = 19'h3_0002;
        repeat (8) @(negedge clk);
        `CHK({vendor_status_bits, alert_oe}, 3'h0)
        ext_fault_pin = 2'h0;
        repeat (8) @(negedge clk);
        `CHK({vendor_status_bits, alert_oe}, 3'h6)
        conclude();
    end
    // A hang is cut short at 120000 cycles, not far past the expected run length.
    initial begin
        repeat (120000) @(negedge clk);
        n_errors++;
        conclude();
    end
endmodule
`default_nettype wire
